// ---- hw/adc_sel_pkg.sv ----
// shared constants and carrier types for the converter input and reference select block
package adc_sel_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFS_INPUT_SELECT = 12'h000;
  localparam logic [11:0] OFS_MISC_CONTROL = 12'h004;
  localparam logic [11:0] OFS_CONV_CONTROL = 12'h008;
  localparam logic [11:0] OFS_RESULT_DATA  = 12'h00C;
  localparam logic [11:0] OFS_ACTIVE_STATE = 12'h010;

  // analog_input_select fields
  localparam int unsigned REF_HIGH_BIT   = 7;
  localparam int unsigned REF_LOW_BIT    = 6;
  localparam int unsigned LEFT_ALIGN_BIT = 5;
  localparam int unsigned CHAN_MSB       = 4;
  localparam int unsigned CHAN_DIFF_BIT  = 4;
  localparam logic [7:0]  INPUT_SELECT_RESET = 8'h00;

  // analog_misc_control fields
  localparam int unsigned EXT_REF_EN_BIT = 0;
  localparam logic [0:0]  MISC_RESET     = 1'h0;

  // conversion control fields
  localparam int unsigned CONV_ENABLE_BIT = 0;
  localparam int unsigned CONV_START_BIT  = 1;
  localparam int unsigned CONV_DONE_BIT   = 2;
  localparam int unsigned CONV_BUSY_BIT   = 3;
  localparam int unsigned CONV_LONG_BIT   = 4;

  // active state fields
  localparam int unsigned ACT_CHAN_LSB = 0;
  localparam int unsigned ACT_REF_LSB  = 8;
  localparam int unsigned ACT_EXT_BIT  = 10;

  // timing in converter clock cycles; converter clock is clk_sys divided
  localparam int unsigned CONV_NORMAL_TICKS = 13;
  localparam int unsigned CONV_LONG_TICKS   = 25;
  localparam int unsigned CONV_CLK_DIV      = 2;
  localparam int unsigned TICK_W            = 5;
  localparam int unsigned DIV_W             = 2;

  localparam int unsigned RESULT_W = 10;
  localparam int unsigned CHAN_MAX_EXTERNAL = 10;

  typedef enum logic [1:0] {
    REF_SUPPLY   = 2'h0,
    REF_EXTERNAL = 2'h1,
    REF_INT_1V1  = 2'h2,
    REF_INT_2V56 = 2'h3
  } ref_source_e;

  typedef enum logic [2:0] {
    SRC_EXTERNAL  = 3'h0,
    SRC_TEMP      = 3'h1,
    SRC_BANDGAP   = 3'h2,
    SRC_QUARTER   = 3'h3,
    SRC_GROUND    = 3'h4,
    SRC_RESERVED  = 3'h5,
    SRC_DIFF_PAIR = 3'h6
  } input_kind_e;

  typedef struct packed {
    input_kind_e kind;
    logic        gain20x;
    logic [3:0]  positive;
    logic [3:0]  negative;
  } input_sel_s;

  typedef struct packed {
    ref_source_e source;
    logic        pinConnect;
  } ref_sel_s;

endpackage

// ---- hw/conv_timer.sv ----
// conversion length timer counting converter clock cycles
`timescale 1ns/1ps
module conv_timer (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic start,
  input  wire logic extended,
  output logic      busy,
  output logic      done
);
  import adc_sel_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } timer_state_e;

  localparam logic [DIV_W-1:0]  DIV_LAST    = DIV_W'(CONV_CLK_DIV - 1);
  localparam logic [TICK_W-1:0] NORMAL_LAST = TICK_W'(CONV_NORMAL_TICKS - 1);
  localparam logic [TICK_W-1:0] LONG_LAST   = TICK_W'(CONV_LONG_TICKS - 1);

  timer_state_e      state;
  logic [DIV_W-1:0]  divCount;
  logic [TICK_W-1:0] tickCount;
  logic [TICK_W-1:0] lastTick;

  wire logic tick     = (divCount == DIV_LAST);
  wire logic finished = tick && (tickCount == lastTick);

  assign busy = (state == ST_RUN);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      divCount  <= '0;
      tickCount <= '0;
      lastTick  <= NORMAL_LAST;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          divCount  <= '0;
          tickCount <= '0;
          if (start && enable) begin
            lastTick <= extended ? LONG_LAST : NORMAL_LAST;
            state    <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!enable) begin
            // switching the converter off abandons the conversion, no done
            state <= ST_IDLE;
          end else begin
            divCount <= tick ? '0 : divCount + 1'b1;
            if (tick) begin
              tickCount <= tickCount + 1'b1;
            end
            if (finished) begin
              done  <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ---- hw/adc_input_reference_select.sv ----
// converter input, reference and alignment selection with APB register access
//
// Operation
// - reference change waits for running conversion end
// - reference change makes next conversion 25 cycles
// - reference from two-bit field plus pin enable
// - low clear, pin off: supply, pin disconnected
// - low clear, pin on: external reference pin
// - low set, pin off: 1.1V or 2.56V
// - alignment bit one left, zero right adjusted
// - alignment change affects data read immediately
// - channel change waits for running conversion end
// - single-ended codes: inputs, sensor, bandgap, supply/4
// - bit four set: differential pairs, gain 8x/20x
// - initializing conversion 25 cycles, normal 13
`timescale 1ns/1ps
module adc_input_reference_select (
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  input  wire logic [adc_sel_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [adc_sel_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [adc_sel_pkg::DATA_W-1:0]   prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [adc_sel_pkg::RESULT_W-1:0] analogResult,
  output adc_sel_pkg::input_sel_s         activeInput,
  output adc_sel_pkg::ref_sel_s           activeReference,
  output logic                            conversionBusy,
  output logic                            conversionDone
);
  import adc_sel_pkg::*;

  // software-visible state
  logic [7:0]          inputSelect;
  logic                extRefEnable;
  logic                convEnable;
  logic                doneFlag;
  logic                longPending;
  logic                startReq;
  logic [RESULT_W-1:0] resultStore;

  // state applied to the analog side
  logic [CHAN_MSB:0]   activeCode;
  logic [1:0]          activeRefBits;
  logic                activeExtEn;

  // pin synchroniser for the analog result
  logic [RESULT_W-1:0] resultMeta;
  logic [RESULT_W-1:0] resultSync;

  logic                enableDelayed;
  logic                timerBusy;
  logic                timerDone;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic access      = psel && penable;
  wire logic accessDone  = access && pready;
  wire logic writeCommit = accessDone && pwrite && pstrb[0];

  wire logic hitInput  = (paddr == OFS_INPUT_SELECT);
  wire logic hitMisc   = (paddr == OFS_MISC_CONTROL);
  wire logic hitConv   = (paddr == OFS_CONV_CONTROL);
  wire logic hitResult = (paddr == OFS_RESULT_DATA);
  wire logic hitActive = (paddr == OFS_ACTIVE_STATE);
  wire logic unmapped  = !(hitInput || hitMisc || hitConv || hitResult || hitActive);

  wire logic writeInput = writeCommit && hitInput;
  wire logic writeMisc  = writeCommit && hitMisc;
  wire logic writeConv  = writeCommit && hitConv;

  wire logic [1:0] newRefBits = pwdata[REF_HIGH_BIT:REF_LOW_BIT];
  wire logic       refChange  = writeInput && (newRefBits != inputSelect[REF_HIGH_BIT:REF_LOW_BIT]);
  wire logic       extChange  = writeMisc && (pwdata[EXT_REF_EN_BIT] != extRefEnable);

  wire logic enableRise = convEnable && !enableDelayed;
  wire logic startTaken = startReq && convEnable && !timerBusy;

  // enable and start in one write: the rise has not reached longPending yet
  wire logic longNeeded = longPending || enableRise;

  // active copies follow the pending ones only when no conversion runs
  wire logic applyPending = !timerBusy || timerDone;

  // ---------------------------------------------------------------
  // result presentation
  // ---------------------------------------------------------------
  wire logic        leftAlign  = inputSelect[LEFT_ALIGN_BIT];
  wire logic [15:0] resultWord = leftAlign ? {resultStore, 6'h00}
                                           : {6'h00, resultStore};

  wire logic [DATA_W-1:0] inputRead = {24'h000000, inputSelect};
  wire logic [DATA_W-1:0] miscRead  = {31'h00000000, extRefEnable};
  wire logic [DATA_W-1:0] convRead  = {27'h0000000, longPending, timerBusy, doneFlag,
                                       timerBusy, convEnable};
  wire logic [DATA_W-1:0] actRead   = {21'h000000, activeExtEn, activeRefBits,
                                       3'h0, activeCode};

  logic [DATA_W-1:0] readMux;

  always_comb begin
    if (hitInput) begin
      readMux = inputRead;
    end else if (hitMisc) begin
      readMux = miscRead;
    end else if (hitConv) begin
      readMux = convRead;
    end else if (hitResult) begin
      readMux = {16'h0000, resultWord};
    end else if (hitActive) begin
      readMux = actRead;
    end else begin
      readMux = '0;
    end
  end

  // ---------------------------------------------------------------
  // decoding of the active selection
  // ---------------------------------------------------------------
  function automatic input_sel_s decode_input(input logic [CHAN_MSB:0] code);
    input_sel_s sel;
    logic [3:0] pairPos;
    sel      = '0;
    pairPos  = 4'h0;
    if (code[CHAN_DIFF_BIT]) begin
      case (code[3:1])
        3'h0:    pairPos = 4'h0;
        3'h1:    pairPos = 4'h1;
        3'h2:    pairPos = 4'h2;
        3'h3:    pairPos = 4'h4;
        3'h4:    pairPos = 4'h5;
        3'h5:    pairPos = 4'h6;
        3'h6:    pairPos = 4'h8;
        default: pairPos = 4'h9;
      endcase
      sel.kind     = SRC_DIFF_PAIR;
      sel.gain20x  = code[0];
      sel.positive = pairPos;
      sel.negative = pairPos + 4'h1;
    end else begin
      sel.positive = code[3:0];
      case (code[3:0])
        4'hB:    sel.kind = SRC_TEMP;
        4'hC:    sel.kind = SRC_BANDGAP;
        4'hD:    sel.kind = SRC_QUARTER;
        4'hE:    sel.kind = SRC_GROUND;
        4'hF:    sel.kind = SRC_RESERVED;
        default: sel.kind = SRC_EXTERNAL;
      endcase
    end
    return sel;
  endfunction

  function automatic ref_sel_s decode_ref(input logic [1:0] bits, input logic extEn);
    ref_sel_s sel;
    sel = '0;
    if (!bits[0] && !extEn) begin
      sel.source     = REF_SUPPLY;
      sel.pinConnect = 1'b0;
    end else if (!bits[0]) begin
      sel.source     = REF_EXTERNAL;
      sel.pinConnect = 1'b1;
    end else begin
      // the pin enable with an internal reference is undefined; the internal one wins
      sel.source     = bits[1] ? REF_INT_2V56 : REF_INT_1V1;
      sel.pinConnect = 1'b0;
    end
    return sel;
  endfunction

  wire input_sel_s nextInput = decode_input(activeCode);
  wire ref_sel_s   nextRef   = decode_ref(activeRefBits, activeExtEn);

  // ---------------------------------------------------------------
  // conversion timer
  // ---------------------------------------------------------------
  conv_timer timer (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .enable   (convEnable),
    .start    (startTaken),
    .extended (longNeeded),
    .busy     (timerBusy),
    .done     (timerDone)
  );

  // ---------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && unmapped;
      prdata  <= (access && !pready && !pwrite) ? readMux : '0;
    end
  end

  // ---------------------------------------------------------------
  // pending registers written by software
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      inputSelect  <= INPUT_SELECT_RESET;
      extRefEnable <= MISC_RESET[0];
    end else begin
      if (writeInput) begin
        inputSelect <= pwdata[7:0];
      end
      if (writeMisc) begin
        extRefEnable <= pwdata[EXT_REF_EN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion control, start request and done flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      convEnable    <= 1'b0;
      enableDelayed <= 1'b0;
      startReq      <= 1'b0;
      doneFlag      <= 1'b0;
    end else begin
      enableDelayed <= convEnable;
      if (writeConv) begin
        convEnable <= pwdata[CONV_ENABLE_BIT];
      end
      // a start written while busy is dropped; writing zero has no effect
      startReq <= writeConv && pwdata[CONV_START_BIT];
      if (timerDone) begin
        doneFlag <= 1'b1;
      end else if (writeConv && pwdata[CONV_DONE_BIT]) begin
        doneFlag <= 1'b0;
      end
    end
  end

  // extended conversion owed after enable or a reference change
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      longPending <= 1'b1;
    end else if (refChange || extChange) begin
      longPending <= 1'b1;
    end else if (startTaken) begin
      // a start in the cycle enable rises consumes the owed long conversion too
      longPending <= 1'b0;
    end else if (enableRise) begin
      longPending <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // active selection, moved over only between conversions
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      activeCode    <= INPUT_SELECT_RESET[CHAN_MSB:0];
      activeRefBits <= INPUT_SELECT_RESET[REF_HIGH_BIT:REF_LOW_BIT];
      activeExtEn   <= MISC_RESET[0];
    end else if (applyPending) begin
      activeCode    <= inputSelect[CHAN_MSB:0];
      activeRefBits <= inputSelect[REF_HIGH_BIT:REF_LOW_BIT];
      activeExtEn   <= extRefEnable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      activeInput     <= '0;
      activeReference <= '0;
      conversionBusy  <= 1'b0;
      conversionDone  <= 1'b0;
    end else begin
      activeInput     <= nextInput;
      activeReference <= nextRef;
      conversionBusy  <= timerBusy;
      conversionDone  <= timerDone;
    end
  end

  // ---------------------------------------------------------------
  // analog result capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resultMeta  <= '0;
      resultSync  <= '0;
      resultStore <= '0;
    end else begin
      resultMeta <= analogResult;
      resultSync <= resultMeta;
      // stored raw so that a later alignment change re-presents it at once
      if (timerDone) begin
        resultStore <= resultSync;
      end
    end
  end

endmodule

// ---- tb/adc_input_reference_select_sva.sv ----
// assertion checker for the input and reference select block
`timescale 1ns/1ps
module adc_input_reference_select_sva (
  input wire logic                   clk_sys,
  input wire logic                   sys_rst,
  input wire logic [11:0]            paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [9:0]             analogResult,
  input wire adc_sel_pkg::input_sel_s activeInput,
  input wire adc_sel_pkg::ref_sel_s   activeReference,
  input wire logic                   conversionBusy,
  input wire logic                   conversionDone
);
  import adc_sel_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [6:0] runLen;
  logic       busyQ;
  logic       doneQ1;
  logic       doneQ2;
  wire        acc   = psel && penable && pready;
  wire        wrSel = acc && pwrite && pstrb[0] && paddr == OFS_INPUT_SELECT;
  wire        rdRes = acc && !pwrite && paddr == OFS_RESULT_DATA;
  wire        midRun = conversionBusy && !doneQ1 && !doneQ2;
  // length is held after busy drops so a late done pulse still sees it
  always_ff @(posedge clk_sys) begin
    busyQ <= conversionBusy && !sys_rst;
    doneQ1 <= conversionDone && !sys_rst;
    doneQ2 <= doneQ1 && !sys_rst;
    if (sys_rst) runLen <= 7'h00;
    else if (conversionBusy) runLen <= busyQ ? runLen + 7'h01 : 7'h01;
  end
  chk_input_hold: assert property (midRun && $past(conversionBusy, 2) |-> $stable(activeInput))
    else $error("active input changed during a conversion");
  chk_ref_hold: assert property (midRun && $past(conversionBusy, 2) |-> $stable(activeReference))
    else $error("active reference changed during a conversion");
  chk_pin_connect: assert property (activeReference.pinConnect == (activeReference.source == REF_EXTERNAL))
    else $error("reference pin connection wrong");
  chk_pair_map: assert property (activeInput.kind == SRC_DIFF_PAIR |->
    activeInput.negative == activeInput.positive + 4'h1 && activeInput.positive != 4'h3)
    else $error("differential pair not adjacent inputs");
  chk_single_range: assert property (activeInput.kind == SRC_EXTERNAL |-> activeInput.positive <= 4'hA)
    else $error("single-ended input out of range");
  chk_conv_length: assert property (conversionDone |-> runLen inside {[22:30], [46:54]})
    else $error("conversion length wrong");
  chk_result_align: assert property (rdRes |->
    prdata[31:16] == 16'h0000 && (prdata[5:0] == 6'h00 || prdata[15:10] == 6'h00))
    else $error("result word not aligned");
  chk_idle_update: assert property (wrSel && !conversionBusy && pwdata[4:0] == 5'h0E ##1 !conversionBusy [*4]
    |-> activeInput.kind == SRC_GROUND)
    else $error("idle selection not applied");
endmodule

bind adc_input_reference_select adc_input_reference_select_sva u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .analogResult(analogResult), .activeInput(activeInput), .activeReference(activeReference),
  .conversionBusy(conversionBusy), .conversionDone(conversionDone)
);

// ---- tb/adc_input_reference_select_tb_top.sv ----
// self-checking bench for the input and reference select block
`timescale 1ns/1ps
module adc_input_reference_select_tb_top;
  import adc_sel_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [9:0]  analogResult = 10'h000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  input_sel_s  activeInput;
  ref_sel_s    activeReference;
  logic        conversionBusy;
  logic        conversionDone;
  logic [31:0] rdData;
  logic        rdErr;
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  localparam logic [3:0] PAIR_POS [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  adc_input_reference_select DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analogResult(analogResult), .activeInput(activeInput), .activeReference(activeReference),
    .conversionBusy(conversionBusy), .conversionDone(conversionDone)
  );

  task automatic test_done();
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; read data and error are taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 1, n < 16);
  endtask

  task automatic waitDone(input int t0, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (conversionDone !== 1'b1 && n < 200);
    chk("conversion length", 1, cyc - t0 >= lo && cyc - t0 <= hi);
  endtask

  task automatic t_reset();
    apb(1'b0, OFS_INPUT_SELECT, 32'h0);
    chk("select reset", 32'h0, rdData);
    apb(1'b0, OFS_MISC_CONTROL, 32'h0);
    chk("misc reset", 32'h0, rdData);
    chk("input reset", 32'h0, activeInput);
    chk("reference reset", 32'h0, activeReference);
  endtask

  task automatic t_ref();
    ref_source_e src;
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 4; r++) begin
        apb(1'b1, OFS_MISC_CONTROL, 32'(p));
        apb(1'b1, OFS_INPUT_SELECT, 32'(r << 6));
        repeat (4) @(posedge clk_sys);
        src = r[0] ? (r[1] ? REF_INT_2V56 : REF_INT_1V1) : (p[0] ? REF_EXTERNAL : REF_SUPPLY);
        chk("reference", {src, !r[0] && p[0]}, activeReference);
      end
    end
    apb(1'b1, OFS_MISC_CONTROL, 32'h0);
  endtask

  task automatic t_chan();
    input_kind_e k;
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, OFS_INPUT_SELECT, 32'(c));
      repeat (4) @(posedge clk_sys);
      k = c[4] ? SRC_DIFF_PAIR : c < 11 ? SRC_EXTERNAL : c == 11 ? SRC_TEMP : c == 12 ? SRC_BANDGAP :
          c == 13 ? SRC_QUARTER : c == 14 ? SRC_GROUND : SRC_RESERVED;
      chk("input kind", k, activeInput.kind);
      if (c[4]) chk("pair", {c[0], PAIR_POS[c[3:1]], PAIR_POS[c[3:1]] + 4'h1}, activeInput[8:0]);
      else if (c < 11) chk("single input", 32'(c), activeInput.positive);
    end
  endtask

  task automatic t_conv();
    int t0;
    analogResult <= 10'h2A5;
    apb(1'b1, OFS_INPUT_SELECT, 32'h00);
    apb(1'b1, OFS_CONV_CONTROL, 32'h3);
    t0 = cyc;
    // new reference and channel while running must wait for the end
    apb(1'b1, OFS_INPUT_SELECT, 32'hD4);
    repeat (4) @(posedge clk_sys);
    chk("held input", 32'h0, activeInput);
    chk("held reference", 32'h0, activeReference);
    chk("busy", 32'h1, conversionBusy);
    waitDone(t0, 48, 58);
    repeat (4) @(posedge clk_sys);
    chk("new input", {SRC_DIFF_PAIR, 1'b0, 4'h2, 4'h3}, activeInput);
    chk("new reference", {REF_INT_2V56, 1'b0}, activeReference);
    apb(1'b0, OFS_RESULT_DATA, 32'h0);
    chk("right aligned", 32'h2A5, rdData);
    apb(1'b1, OFS_INPUT_SELECT, 32'hF4);
    apb(1'b0, OFS_RESULT_DATA, 32'h0);
    chk("left aligned", 32'hA940, rdData);
    analogResult <= 10'h155;
    apb(1'b1, OFS_CONV_CONTROL, 32'h3);
    t0 = cyc;
    apb(1'b1, OFS_INPUT_SELECT, 32'hD4);
    apb(1'b0, OFS_RESULT_DATA, 32'h0);
    chk("align while busy", 32'h2A5, rdData);
    // the reference moved during the previous run, so this one is long
    waitDone(t0, 48, 58);
    apb(1'b0, OFS_RESULT_DATA, 32'h0);
    chk("captured result", 32'h155, rdData);
    // reference change while idle still owes a long conversion
    apb(1'b1, OFS_INPUT_SELECT, 32'h14);
    apb(1'b1, OFS_CONV_CONTROL, 32'h3);
    t0 = cyc;
    waitDone(t0, 48, 58);
    // nothing owed any more: a normal conversion
    apb(1'b1, OFS_CONV_CONTROL, 32'h3);
    t0 = cyc;
    waitDone(t0, 24, 34);
    apb(1'b0, OFS_CONV_CONTROL, 32'h0);
    chk("conversion status", 32'h5, rdData);
  endtask

  task automatic t_refused();
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped error", 32'h1, rdErr);
    chk("unmapped data", 32'h0, rdData);
    pstrb <= 4'hE;
    apb(1'b1, OFS_INPUT_SELECT, 32'h3F);
    pstrb <= 4'hF;
    apb(1'b0, OFS_INPUT_SELECT, 32'h0);
    chk("masked write", 32'h14, rdData);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_ref();
    t_chan();
    t_conv();
    t_refused();
    test_done();
  end

  // about sixteen times the expected run
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule
